// *** hw/las_top.sv ***
/*
  Link alarm collector: sticky alarm flags, masks, summary alarm,
  per-lane buffer faults, interrupt status/enable and an Avalon-MM slave.
  Assumes the link, PLL and lane logic drive the condition inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module las_top
  import las_pkg::*;
#(
  parameter int unsigned LANES = LANES_MAX
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output var  logic [DATA_W-1:0] avs_readdata,
  output var  logic              avs_waitrequest,
  // Alarm conditions
  input  wire logic              pll_lock_async,
  input  wire logic              div_mismatch_async,
  input  wire logic [LANES-1:0]  lane_fault,
  input  wire logic [LANES-1:0]  lane_active,
  input  wire logic              link_data_state,
  input  wire logic              link_realign,
  input  wire logic              sysref_realign,
  // Outputs
  output var  logic              serial_link_enable,
  output var  logic              alarm_summary,
  output var  logic              calibration_status_pin,
  output var  logic              irq
);

  if (LANES < 1 || LANES > LANES_MAX)
  begin : g_bad_lanes
    $error("LANES must lie between 1 and 8");
  end

  las_cond_if #(.LANES(LANES)) ci ();

  las_bus_e         state_reg;
  logic [7:0]       flags_reg;
  logic [7:0]       masks_reg;
  logic [LANES-1:0] lanes_reg;
  logic [7:0]       irq_stat_reg;
  logic [7:0]       irq_en_reg;
  logic [7:0]       ctrl_reg;
  logic [7:0]       rd_mux;
  logic [7:0]       wbyte;
  logic [7:0]       clr_flags;
  logic [LANES-1:0] clr_lanes;
  logic             wr_acc;
  logic             soft_rst;
  logic             summary_now;

  // Condition front end
  las_cond #(.LANES(LANES)) u_cond (
    .clk                (clk),
    .reset_n            (reset_n),
    .pll_lock_async     (pll_lock_async),
    .div_mismatch_async (div_mismatch_async),
    .lane_fault         (lane_fault),
    .lane_active        (lane_active),
    .link_data_state    (link_data_state),
    .link_realign       (link_realign),
    .sysref_realign     (sysref_realign),
    .ci                 (ci)
  );

  assign ci.link_enable = ctrl_reg[CTRL_LINK_EN];
  assign ci.mode_66     = ctrl_reg[CTRL_MODE66];

  // A write takes effect only at the edge where waitrequest is seen low
  assign wr_acc = avs_write && (state_reg == LAS_ANSWER) && avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];

  // Write-one-to-clear strobes and the write-one soft reset strobe
  assign clr_flags = (wr_acc && las_hit(avs_address, IDX_FLAGS)) ? (wbyte & FLAGS_W1C) : 8'h00;
  assign clr_lanes = (wr_acc && las_hit(avs_address, IDX_LANES)) ? wbyte[LANES-1:0]
                   : '0;
  assign soft_rst  = wr_acc && las_hit(avs_address, IDX_CTRL) && wbyte[CTRL_SOFT_RST];

  // Bus answer: one wait cycle, then the answer cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg       <= LAS_IDLE;
      avs_waitrequest <= 1'b1;
    end
    else
      case (state_reg)
        LAS_IDLE:
          if (avs_read || avs_write)
          begin
            state_reg       <= LAS_ANSWER;
            avs_waitrequest <= 1'b0;
          end
        LAS_ANSWER:
        begin
          state_reg       <= LAS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
        begin
          state_reg       <= LAS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
  end

  // Read multiplexer; unmapped and write-only words read zero
  always_comb
  begin
    case (avs_address)
      IDX_SUMMARY:  rd_mux = {7'h00, alarm_summary};
      IDX_FLAGS:    rd_mux = flags_reg;
      IDX_MASKS:    rd_mux = masks_reg;
      IDX_LANES:    rd_mux = 8'(lanes_reg);
      IDX_IRQ_STAT: rd_mux = irq_stat_reg;
      IDX_IRQ_EN:   rd_mux = irq_en_reg;
      IDX_CTRL:     rd_mux = ctrl_reg;
      default:      rd_mux = 8'h00;
    endcase
  end

  // Read data is captured as waitrequest falls and held after
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      avs_readdata <= '0;
    else if (state_reg == LAS_IDLE && avs_read)
      avs_readdata <= {24'h000000, rd_mux};
  end

  // Alarm flags: hardware set beats software clear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_reg <= FLAGS_RST;
    else if (soft_rst)
      flags_reg <= FLAGS_RST;
    else
      flags_reg <= (flags_reg & ~clr_flags) | ci.set_req;
  end
  // Flags other than the link flag keep latching with the link off; software clears them on enable.

  // Per-lane buffer faults, also wiped by clearing the summary lane flag
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lanes_reg <= LANES_RST[LANES-1:0];
    else if (soft_rst)
      lanes_reg <= LANES_RST[LANES-1:0];
    else if (clr_flags[BIT_LANE])
      lanes_reg <= ci.lane_set;
    else
      lanes_reg <= (lanes_reg & ~clr_lanes) | ci.lane_set;
  end

  // Mask register stores all eight bits as written
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      masks_reg <= MASKS_RST;
    else if (soft_rst)
      masks_reg <= MASKS_RST;
    else if (wr_acc && las_hit(avs_address, IDX_MASKS))
      masks_reg <= wbyte;
  end

  // Control: soft reset bit self-clears, never stored
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_reg <= CTRL_RST;
    else if (wr_acc && las_hit(avs_address, IDX_CTRL))
      ctrl_reg <= wbyte & CTRL_WMASK;
  end

  assign serial_link_enable = ctrl_reg[CTRL_LINK_EN];

  // Interrupt status latches raw set events, cleared through its clear word
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_stat_reg <= 8'h00;
    else if (soft_rst)
      irq_stat_reg <= 8'h00;
    else if (wr_acc && las_hit(avs_address, IDX_IRQ_CLR))
      irq_stat_reg <= (irq_stat_reg & ~wbyte) | ci.set_req;
    else
      irq_stat_reg <= irq_stat_reg | ci.set_req;
  end

  // Interrupt enable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_en_reg <= IRQ_EN_RST;
    else if (wr_acc && las_hit(avs_address, IDX_IRQ_EN))
      irq_en_reg <= wbyte;
  end

  // Reserved flag bit 1 never reaches the summary
  assign summary_now = |(flags_reg & ~masks_reg & LIVE_BITS);

  // Registered outputs; the pin copy costs one cycle but stays glitch free
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      alarm_summary          <= 1'b0;
      calibration_status_pin <= 1'b0;
      irq                    <= 1'b0;
    end
    else
    begin
      alarm_summary          <= summary_now;
      calibration_status_pin <= summary_now && ctrl_reg[CTRL_ROUTE];
      irq                    <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_lane_set;
    |(lane_fault & lane_active) |=> flags_reg[BIT_LANE];
  endproperty
  a_lane_set: assert property (p_lane_set) else $error("lane fault not flagged");

  property p_w1c;
    (clr_flags[BIT_REALIGN] && !sysref_realign) |=> !flags_reg[BIT_REALIGN];
  endproperty
  a_w1c: assert property (p_w1c) else $error("realign flag not cleared");

  property p_pll;
    (!pll_lock_async)[*5] |=> flags_reg[BIT_PLL];
  endproperty
  a_pll: assert property (p_pll) else $error("pll unlock not flagged");

  property p_link8;
    (!ctrl_reg[CTRL_MODE66] && ctrl_reg[CTRL_LINK_EN] && !link_data_state)
      |=> flags_reg[BIT_LINK];
  endproperty
  a_link8: assert property (p_link8) else $error("link state not flagged");

  property p_link66;
    (ctrl_reg[CTRL_MODE66] && $rose(ctrl_reg[CTRL_LINK_EN])) |=> flags_reg[BIT_LINK];
  endproperty
  a_link66: assert property (p_link66) else $error("link start not flagged");

  property p_sysref;
    sysref_realign |=> flags_reg[BIT_REALIGN] ##1 1;
  endproperty
  a_sysref: assert property (p_sysref) else $error("realign not flagged");

  property p_div;
    div_mismatch_async[*5] |=> flags_reg[BIT_DIV];
  endproperty
  a_div: assert property (p_div) else $error("divider mismatch not flagged");

  property p_soft_flags;
    soft_rst |=> (flags_reg[5:0] == 6'h3f);
  endproperty
  a_soft_flags: assert property (p_soft_flags) else $error("flags not set by reset");

  property p_soft_masks;
    soft_rst |=> (masks_reg == MASKS_RST) ##1 !alarm_summary;
  endproperty
  a_soft_masks: assert property (p_soft_masks) else $error("masks not defaulted");

  property p_masked;
    ((flags_reg & ~masks_reg & LIVE_BITS) == 8'h00)[*2] |-> !alarm_summary;
  endproperty
  a_masked: assert property (p_masked) else $error("masked alarm leaked");

  property p_summary;
    (flags_reg[BIT_DIV] && !masks_reg[BIT_DIV]) |=> alarm_summary;
  endproperty
  a_summary: assert property (p_summary) else $error("summary missed alarm");

  property p_lane_wipe;
    (clr_flags[BIT_LANE] && !(|(lane_fault & lane_active))) |=> (lanes_reg == '0);
  endproperty
  a_lane_wipe: assert property (p_lane_wipe) else $error("lane faults not wiped");

  property p_sticky;
    $fell(flags_reg[BIT_PLL]) |-> $past(clr_flags[BIT_PLL]) && !soft_rst;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped on its own");

  property p_answer;
    (state_reg == LAS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer out of time");

  // A realignment while the link runs in 64b/66b must raise the link flag
  property p_realign66;
    (ctrl_reg[CTRL_MODE66] && ctrl_reg[CTRL_LINK_EN] && link_realign) |=> flags_reg[BIT_LINK];
  endproperty
  a_realign66: assert property (p_realign66) else $error("realign not flagged");

  property p_pin;
    calibration_status_pin |-> $past(summary_now && ctrl_reg[CTRL_ROUTE]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin raised without routed alarm");

  // Interrupt level follows enabled status one cycle later
  property p_irq;
    (|(irq_stat_reg & irq_en_reg)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_lane_bit;
    (lane_fault[0] && lane_active[0]) |=> lanes_reg[0];
  endproperty
  a_lane_bit: assert property (p_lane_bit) else $error("lane fault bit not latched");

  c_clear:   cover property (clr_flags != 8'h00 ##1 flags_reg == 8'h00);
  c_summary: cover property (!alarm_summary ##1 alarm_summary);
  c_irq:     cover property ($rose(irq));
  c_soft:    cover property (soft_rst);
  c_realign: cover property (ctrl_reg[CTRL_MODE66] && link_realign);

endmodule : las_top

`default_nettype wire

// *** hw/las_pkg.sv ***
/*
  Constants for the link alarm collector: register indices, field
  positions, reset values and the address decode helper.
  Assumes a word-addressed Avalon-MM slave port with 32-bit data.
*/
package las_pkg;

  // Bus shape
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned LANES_MAX = 8;

  // Register indices; the byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_SUMMARY  = 10'h2c0;
  localparam logic [ADDR_W-1:0] IDX_FLAGS    = 10'h2c1;
  localparam logic [ADDR_W-1:0] IDX_MASKS    = 10'h2c2;
  localparam logic [ADDR_W-1:0] IDX_LANES    = 10'h2c4;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 10'h2d0;
  localparam logic [ADDR_W-1:0] IDX_IRQ_CLR  = 10'h2d1;
  localparam logic [ADDR_W-1:0] IDX_IRQ_EN   = 10'h2d2;
  localparam logic [ADDR_W-1:0] IDX_CTRL     = 10'h2d3;

  // Flag and mask bit positions
  localparam int unsigned BIT_LANE    = 5;
  localparam int unsigned BIT_PLL     = 4;
  localparam int unsigned BIT_LINK    = 3;
  localparam int unsigned BIT_REALIGN = 2;
  localparam int unsigned BIT_DIV     = 0;

  // Control bit positions
  localparam int unsigned CTRL_LINK_EN  = 0;
  localparam int unsigned CTRL_MODE66   = 1;
  localparam int unsigned CTRL_SOFT_RST = 2;
  localparam int unsigned CTRL_ROUTE    = 3;

  // Reset values and bit groups
  localparam logic [7:0] FLAGS_RST  = 8'h3f;
  localparam logic [7:0] MASKS_RST  = 8'h3f;
  localparam logic [7:0] LANES_RST  = 8'hff;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] FLAGS_W1C  = 8'h3f;
  localparam logic [7:0] LIVE_BITS  = 8'h3d;
  localparam logic [7:0] CTRL_WMASK = 8'h0b;

  // Bus answer states
  typedef enum logic {LAS_IDLE, LAS_ANSWER} las_bus_e;

  // Address decode shared by every register write
  function automatic logic las_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] idx);
    return addr == idx;
  endfunction : las_hit

endpackage : las_pkg

// *** hw/las_cond_if.sv ***
/*
  Carrier between the register block and the condition front end.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface las_cond_if #(parameter int unsigned LANES = 8);
  logic             link_enable;
  logic             mode_66;
  logic [7:0]       set_req;
  logic [LANES-1:0] lane_set;

  // Front end produces set requests
  modport src  (input link_enable, input mode_66, output set_req, output lane_set);
  // Register block consumes them
  modport sink (output link_enable, output mode_66, input set_req, input lane_set);
endinterface : las_cond_if

`default_nettype wire

// *** hw/las_cond.sv ***
/*
  Condition front end: synchronises the asynchronous lock and divider
  levels and turns every alarm condition into a per-cycle set request.
  Assumes lane, link and SYSREF event inputs are on clk already.
*/
`timescale 1ns/1ps
`default_nettype none

module las_cond
  import las_pkg::*;
#(
  parameter int unsigned LANES = LANES_MAX
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Asynchronous levels
  input  wire logic             pll_lock_async,
  input  wire logic             div_mismatch_async,
  // Same-clock conditions
  input  wire logic [LANES-1:0] lane_fault,
  input  wire logic [LANES-1:0] lane_active,
  input  wire logic             link_data_state,
  input  wire logic             link_realign,
  input  wire logic             sysref_realign,
  // Set requests to the register block
  las_cond_if.src               ci
);

  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] filt_reg;
  logic       en_prev_reg;
  logic       start_66;

  // Three-stage synchroniser; bit 0 lock, bit 1 mismatch
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
    end
    else
    begin
      s1_reg <= {div_mismatch_async, pll_lock_async};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts once stages two and three agree; glitches are dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      filt_reg <= 2'h0;
    else
      for (int i = 0; i < 2; i++)
        if (s2_reg[i] == s3_reg[i])
          filt_reg[i] <= s3_reg[i];
  end

  // Link enable history for start-up detection
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      en_prev_reg <= 1'b0;
    else
      en_prev_reg <= ci.link_enable;
  end

  assign start_66 = ci.link_enable && !en_prev_reg;

  // Set requests; reserved positions never request
  always_comb
  begin
    ci.set_req              = 8'h00;
    ci.set_req[BIT_LANE]    = |(lane_fault & lane_active);
    ci.set_req[BIT_PLL]     = !filt_reg[0];
    if (ci.mode_66)
      ci.set_req[BIT_LINK]  = start_66 || (ci.link_enable && link_realign);
    else
      ci.set_req[BIT_LINK]  = ci.link_enable && !link_data_state;
    ci.set_req[BIT_REALIGN] = sysref_realign;
    ci.set_req[BIT_DIV]     = filt_reg[1];
  end

  assign ci.lane_set = lane_fault & lane_active;

endmodule : las_cond

`default_nettype wire

// *** test/las_testbench.sv ***
/*
  Self-checking bench for the link alarm collector: a register-bus master,
  condition stimulus, an integer model of flags and masks, and fixed-value interrupt checks.
  Assumes the top module answers each bus request after one wait cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import las_pkg::*;

  // Design ports
  logic              clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  logic [3:0]        avs_byteenable;
  logic              pll_lock_async, div_mismatch_async, link_data_state;
  logic              link_realign, sysref_realign;
  logic [7:0]        lane_fault, lane_active;
  logic              serial_link_enable, alarm_summary, calibration_status_pin, irq;
  // Bench state
  int                fails, comparisons, exp_flags, exp_masks, ln;
  int                flag_order[$] = '{5, 4, 3, 2, 0};
  logic [31:0]       seed;
  logic [7:0]        rd;

  las_top #(.LANES(8)) uut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pll_lock_async(pll_lock_async),
    .div_mismatch_async(div_mismatch_async), .lane_fault(lane_fault),
    .lane_active(lane_active), .link_data_state(link_data_state),
    .link_realign(link_realign), .sysref_realign(sysref_realign),
    .serial_link_enable(serial_link_enable), .alarm_summary(alarm_summary),
    .calibration_status_pin(calibration_status_pin), .irq(irq));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q);
    int n;
    n = 0;
    seed = xs(seed);
    @(posedge clk);
    avs_address    <= a;
    avs_writedata  <= {seed[23:0], d};  // Upper bits are noise the block must ignore
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      check(32'h0, 32'h1);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hf, rd);
    check({24'h0, rd}, {24'h0, e});
  endtask : rd_chk

  // Raise or drop the condition behind flag bit b
  task automatic cond(input int b, input logic v);
    @(posedge clk);
    case (b)
      5: lane_fault <= v ? (8'h01 << ln) : 8'h00;
      4: pll_lock_async <= !v;
      3: link_data_state <= !v;
      2: sysref_realign <= v;
      default: div_mismatch_async <= v;
    endcase
    repeat (8) @(posedge clk);  // Covers the synchroniser on the slow levels
  endtask : cond

  // Watchdog, far beyond the planned run
  initial
  begin
    #(40 * 20000);
    fails++;
    give_verdict();
  end

  initial
  begin
    reset_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; avs_byteenable = 4'hf; pll_lock_async = 1'b1;
    div_mismatch_async = 1'b0; lane_fault = 8'h00; lane_active = 8'hff;
    link_data_state = 1'b1; link_realign = 1'b0; sysref_realign = 1'b0;
    fails = 0; comparisons = 0; seed = 32'hdfa2efe3;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    // Reset values and the unmapped hole
    rd_chk(IDX_FLAGS, 8'h3f);
    rd_chk(IDX_MASKS, 8'h3f);
    rd_chk(IDX_LANES, 8'hff);
    rd_chk(10'h2c3, 8'h00);
    wr(10'h2c3, 8'h5a);
    rd_chk(10'h2c3, 8'h00);
    $display("reset values done");
    // Enable the link routed to the pin, then clear every flag
    wr(IDX_CTRL, 8'h09);
    wr(IDX_FLAGS, 8'h3f);
    exp_flags = 0;
    exp_masks = 8'h3f;
    rd_chk(IDX_FLAGS, exp_flags[7:0]);
    // Each condition in turn: set, sticky, write-zero, summary, clear
    foreach (flag_order[k])
    begin
      int b;
      b = flag_order[k];
      seed = xs(seed);
      ln = seed[2:0];
      if (b == 5)
      begin
        lane_active <= 8'hff ^ (8'h01 << ln);  // Inactive lane must not raise the flag
        cond(5, 1'b1);
        cond(5, 1'b0);
        rd_chk(IDX_FLAGS, 8'h00);
        lane_active <= 8'hff;
      end
      cond(b, 1'b1);
      cond(b, 1'b0);
      exp_flags = 1 << b;
      rd_chk(IDX_FLAGS, exp_flags[7:0]);
      wr(IDX_FLAGS, 8'h00);
      rd_chk(IDX_FLAGS, exp_flags[7:0]);
      check({31'h0, alarm_summary}, 32'h0);
      exp_masks = 8'h3f & ~(1 << b);
      wr(IDX_MASKS, exp_masks[7:0]);
      repeat (3) @(posedge clk);
      check({31'h0, alarm_summary}, 32'h1);
      check({31'h0, calibration_status_pin}, 32'h1);
      rd_chk(IDX_SUMMARY, 8'h01);
      rd_chk(IDX_MASKS, exp_masks[7:0]);
      if (b == 5)
      begin
        rd_chk(IDX_LANES, 8'h01 << ln);
        wr(IDX_FLAGS, 8'h20);
        rd_chk(IDX_LANES, 8'h00);
      end
      else
        wr(IDX_FLAGS, 8'h01 << b);
      exp_flags = 0;
      rd_chk(IDX_FLAGS, 8'h00);
      rd_chk(IDX_SUMMARY, 8'h00);
      check({31'h0, calibration_status_pin}, 32'h0);
      exp_masks = 8'h3f;
      wr(IDX_MASKS, 8'h3f);
      $display("flag %0d done", b);
    end
    // A write with byte lane 0 disabled changes nothing
    bus(1'b1, IDX_MASKS, 8'h00, 4'he, rd);
    rd_chk(IDX_MASKS, 8'h3f);
    // Live condition sets the flag again after a clear
    @(posedge clk);
    pll_lock_async <= 1'b0;
    repeat (8) @(posedge clk);
    wr(IDX_FLAGS, 8'h10);
    rd_chk(IDX_FLAGS, 8'h10);
    cond(4, 1'b0);
    wr(IDX_FLAGS, 8'h10);
    rd_chk(IDX_FLAGS, 8'h00);
    $display("re-set test done");
    // 64b/66b: start-up and realignment both raise the link flag
    wr(IDX_CTRL, 8'h02);
    wr(IDX_FLAGS, 8'h3f);
    wr(IDX_CTRL, 8'h03);
    rd_chk(IDX_FLAGS, 8'h08);
    wr(IDX_FLAGS, 8'h08);
    rd_chk(IDX_FLAGS, 8'h00);
    @(posedge clk);
    link_realign <= 1'b1;
    @(posedge clk);
    link_realign <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(IDX_FLAGS, 8'h08);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_FLAGS, 8'h3f);
    $display("wide mode done");
    // Interrupt: enabled event, clear, then disabled event
    wr(IDX_IRQ_CLR, 8'hff);
    rd_chk(IDX_IRQ_CLR, 8'h00);
    wr(IDX_IRQ_EN, 8'h04);
    rd_chk(IDX_IRQ_EN, 8'h04);
    check({31'h0, irq}, 32'h0);
    cond(2, 1'b1);
    cond(2, 1'b0);
    check({31'h0, irq}, 32'h1);
    rd_chk(IDX_IRQ_STAT, 8'h04);
    wr(IDX_IRQ_CLR, 8'h04);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_EN, 8'h00);
    cond(2, 1'b1);
    cond(2, 1'b0);
    check({31'h0, irq}, 32'h0);
    $display("interrupt done");
    // Soft reset restores flags and masks, leaves the link enabled
    wr(IDX_MASKS, 8'h02);
    wr(IDX_CTRL, 8'h05);
    rd_chk(IDX_FLAGS, 8'h3f);
    rd_chk(IDX_MASKS, 8'h3f);
    rd_chk(IDX_CTRL, 8'h01);
    check({31'h0, serial_link_enable}, 32'h1);
    $display("soft reset done");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
